// *** rtl/cmdc_pkg.sv ***
// Shared constants, types and register map of the CAN mailbox data and command block
package cmdc_pkg;

  // Widths
  localparam int MB_IDX_W = 4;
  localparam int DATA_W = 32;
  localparam int DLC_W = 4;
  localparam int PRIO_W = 4;
  localparam int TYPE_W = 3;
  localparam int ADDR_W = 12;
  localparam int MB_OFF_W = 5;

  typedef logic [MB_IDX_W-1:0] cmdc_mb_idx_type;

  // Global registers, byte addresses
  localparam logic [ADDR_W-1:0] GLOBAL_TRANSFER_OFF = 12'h000;
  localparam logic [ADDR_W-1:0] GLOBAL_ABORT_OFF = 12'h004;

  // Mailbox region: address[11:9] selects it, address[8:5] the mailbox, address[4:0] the register
  localparam int MB_REGION_LSB = 9;
  localparam logic [ADDR_W-MB_REGION_LSB-1:0] MB_REGION_ID = 3'h1;
  localparam int MB_IDX_LSB = 5;
  localparam logic [MB_OFF_W-1:0] MODE_OFF = 5'h00;
  localparam logic [MB_OFF_W-1:0] STATUS_OFF = 5'h10;
  localparam logic [MB_OFF_W-1:0] DATA_LOW_OFF = 5'h14;
  localparam logic [MB_OFF_W-1:0] DATA_HIGH_OFF = 5'h18;
  localparam logic [MB_OFF_W-1:0] COMMAND_OFF = 5'h1c;

  // Command register fields
  localparam int CMD_XFER_BIT = 23;
  localparam int CMD_ABORT_BIT = 22;
  localparam int CMD_RTR_BIT = 20;
  localparam int CMD_DLC_LSB = 16;

  // Status register fields
  localparam int ST_IGNORED_BIT = 24;
  localparam int ST_READY_BIT = 23;
  localparam int ST_ABORT_BIT = 22;
  localparam int ST_RTR_BIT = 20;
  localparam int ST_DLC_LSB = 16;

  // Mode register fields
  localparam int MODE_TYPE_LSB = 24;
  localparam int MODE_PRIO_LSB = 16;

  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

  // Mailbox object types
  typedef enum logic [TYPE_W-1:0] {
    OBJ_DISABLED = 3'b000,
    OBJ_RX = 3'b001,
    OBJ_RX_OVR = 3'b010,
    OBJ_TX = 3'b011,
    OBJ_CONSUMER = 3'b100,
    OBJ_PRODUCER = 3'b101
  } cmdc_obj_type;

  // Transmit engine state
  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_BUSY = 1'b1
  } cmdc_tx_state_type;

  // Frame exchanged with the protocol engine
  typedef struct packed {
    cmdc_mb_idx_type mb;
    logic [DATA_W-1:0] data_high;
    logic [DATA_W-1:0] data_low;
    logic [DLC_W-1:0] dlc;
    logic rtr;
  } cmdc_frame_type;

endpackage : cmdc_pkg

// *** rtl/cmdc_mailbox.sv ***
// Mailbox data words, command decode and transmit arbitration for a CAN controller
`timescale 1ns/10ps
module cmdc_mailbox #(
  parameter int N_MB = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [cmdc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [cmdc_pkg::DATA_W-1:0] avs_writedata,
  output logic [cmdc_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic tx_valid,
  input wire logic tx_ready,
  output cmdc_pkg::cmdc_frame_type tx_frame,
  input wire logic tx_done,
  input wire logic tx_lost,
  input wire logic rx_valid,
  input wire cmdc_pkg::cmdc_frame_type rx_frame,
  output logic abort_irq
);

  localparam int PW = cmdc_pkg::PRIO_W;

  // Per-mailbox storage
  logic [cmdc_pkg::DATA_W-1:0] data_low_reg [N_MB];
  logic [cmdc_pkg::DATA_W-1:0] data_high_reg [N_MB];
  logic [cmdc_pkg::TYPE_W-1:0] obj_reg [N_MB];
  logic [PW-1:0] prio_reg [N_MB];
  logic [cmdc_pkg::DLC_W-1:0] dlc_reg [N_MB];
  logic [N_MB-1:0] rtr_reg;
  logic [N_MB-1:0] ready_reg;
  logic [N_MB-1:0] abort_done_reg;
  logic [N_MB-1:0] ignored_reg;
  logic [N_MB-1:0] pending_reg;
  logic [N_MB-1:0] remote_seen_reg;
  logic [N_MB-1:0] remote_sent_reg;

  // Bus and transmit engine state
  logic ack_reg;
  logic [cmdc_pkg::DATA_W-1:0] rdata_reg;
  cmdc_pkg::cmdc_tx_state_type tx_state_reg;
  cmdc_pkg::cmdc_mb_idx_type busy_mb_reg;
  logic offer_reg;
  cmdc_pkg::cmdc_frame_type offer_frame_reg;

  // Decoded events
  logic wr_fire;
  logic rd_fire;
  logic in_mb;
  cmdc_pkg::cmdc_mb_idx_type acc_idx;
  logic [cmdc_pkg::MB_OFF_W-1:0] acc_off;
  logic gtr_wr;
  logic gar_wr;
  logic [N_MB-1:0] xfer_cmd;
  logic [N_MB-1:0] abort_cmd;
  logic [N_MB-1:0] cmd_wr;
  logic [N_MB-1:0] mode_wr;
  logic [N_MB-1:0] status_rd;
  logic [N_MB-1:0] dl_wr;
  logic [N_MB-1:0] dh_wr;
  logic [N_MB-1:0] rx_hit;
  logic [N_MB-1:0] rx_store;
  logic [N_MB-1:0] cand;
  logic [N_MB-1:0] in_flight;
  logic [N_MB-1:0] done_hit;
  logic [N_MB*PW-1:0] prio_flat;
  cmdc_pkg::cmdc_mb_idx_type winner;

  // True when this access targets register want of mailbox i
  function automatic logic mb_hit(input logic hit_region, input cmdc_pkg::cmdc_mb_idx_type idx,
                                  input logic [cmdc_pkg::MB_OFF_W-1:0] off, input int i,
                                  input logic [cmdc_pkg::MB_OFF_W-1:0] want);
    return hit_region && (idx == cmdc_pkg::cmdc_mb_idx_type'(i)) && (off == want);
  endfunction : mb_hit

  // Highest priority (lowest value) wins; scanning downward lets the lower number win ties
  function automatic cmdc_pkg::cmdc_mb_idx_type pick_winner(input logic [N_MB-1:0] c,
                                                            input logic [N_MB*PW-1:0] p);
    cmdc_pkg::cmdc_mb_idx_type best;
    logic [PW-1:0] best_p;
    best = '0;
    best_p = '1;
    for (int i = N_MB - 1; i >= 0; i--) begin
      if (c[i] && (p[i*PW +: PW] <= best_p)) begin
        best = cmdc_pkg::cmdc_mb_idx_type'(i);
        best_p = p[i*PW +: PW];
      end
    end
    return best;
  endfunction : pick_winner

  // Type tests on the raw mode field; undefined codes behave as disabled
  function automatic logic is_type(input logic [cmdc_pkg::TYPE_W-1:0] t, input cmdc_pkg::cmdc_obj_type want);
    return t == want;
  endfunction : is_type

  // Avalon handshake: every access is answered on its second cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_fire = avs_write & ack_reg;
  assign rd_fire = avs_read & ack_reg;
  assign acc_idx = avs_address[cmdc_pkg::MB_IDX_LSB +: cmdc_pkg::MB_IDX_W];
  assign acc_off = avs_address[cmdc_pkg::MB_OFF_W-1:0];
  assign in_mb = (avs_address[cmdc_pkg::ADDR_W-1:cmdc_pkg::MB_REGION_LSB] == cmdc_pkg::MB_REGION_ID)
                 && (int'(acc_idx) < N_MB);
  assign gtr_wr = wr_fire && (avs_address == cmdc_pkg::GLOBAL_TRANSFER_OFF);
  assign gar_wr = wr_fire && (avs_address == cmdc_pkg::GLOBAL_ABORT_OFF);

  // Per-mailbox decode of bus, receive and transmit events
  always_comb begin
    for (int i = 0; i < N_MB; i++) begin
      cmd_wr[i] = wr_fire && mb_hit(in_mb, acc_idx, acc_off, i, cmdc_pkg::COMMAND_OFF);
      mode_wr[i] = wr_fire && mb_hit(in_mb, acc_idx, acc_off, i, cmdc_pkg::MODE_OFF);
      status_rd[i] = rd_fire && mb_hit(in_mb, acc_idx, acc_off, i, cmdc_pkg::STATUS_OFF);
      dl_wr[i] = wr_fire && ready_reg[i] && mb_hit(in_mb, acc_idx, acc_off, i, cmdc_pkg::DATA_LOW_OFF);
      dh_wr[i] = wr_fire && ready_reg[i] && mb_hit(in_mb, acc_idx, acc_off, i, cmdc_pkg::DATA_HIGH_OFF);
      // Only the documented command bits are decoded; the rest fall away
      xfer_cmd[i] = (cmd_wr[i] && avs_writedata[cmdc_pkg::CMD_XFER_BIT])
                    || (gtr_wr && avs_writedata[i]);
      abort_cmd[i] = (cmd_wr[i] && avs_writedata[cmdc_pkg::CMD_ABORT_BIT])
                     || (gar_wr && avs_writedata[i]);
      in_flight[i] = (tx_state_reg == cmdc_pkg::TX_BUSY) && (busy_mb_reg == cmdc_pkg::cmdc_mb_idx_type'(i));
      done_hit[i] = in_flight[i] && tx_done;
      rx_hit[i] = rx_valid && (rx_frame.mb == cmdc_pkg::cmdc_mb_idx_type'(i));
      // Receive keeps the first frame, overwrite keeps the latest even while software reads
      rx_store[i] = rx_hit[i] && pending_reg[i]
                    && (((is_type(obj_reg[i], cmdc_pkg::OBJ_RX) || is_type(obj_reg[i], cmdc_pkg::OBJ_CONSUMER))
                         && !ready_reg[i])
                        || is_type(obj_reg[i], cmdc_pkg::OBJ_RX_OVR));
      cand[i] = pending_reg[i] && !in_flight[i]
                && (is_type(obj_reg[i], cmdc_pkg::OBJ_TX)
                    || (is_type(obj_reg[i], cmdc_pkg::OBJ_CONSUMER) && !remote_sent_reg[i])
                    || (is_type(obj_reg[i], cmdc_pkg::OBJ_PRODUCER) && remote_seen_reg[i]));
      prio_flat[i*PW +: PW] = prio_reg[i];
    end
  end

  assign winner = pick_winner(cand, prio_flat);

  // Bus acknowledge sequencing
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  // Read data is captured in the wait cycle so it stands at the answering edge
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_reg <= cmdc_pkg::ZERO_WORD;
    end else if (avs_read && !ack_reg) begin
      rdata_reg <= cmdc_pkg::ZERO_WORD;
      if (in_mb) begin
        unique case (acc_off)
          cmdc_pkg::MODE_OFF: begin
            rdata_reg[cmdc_pkg::MODE_TYPE_LSB +: cmdc_pkg::TYPE_W] <= obj_reg[acc_idx];
            rdata_reg[cmdc_pkg::MODE_PRIO_LSB +: PW] <= prio_reg[acc_idx];
          end
          cmdc_pkg::STATUS_OFF: begin
            rdata_reg[cmdc_pkg::ST_IGNORED_BIT] <= ignored_reg[acc_idx];
            rdata_reg[cmdc_pkg::ST_READY_BIT] <= ready_reg[acc_idx];
            rdata_reg[cmdc_pkg::ST_ABORT_BIT] <= abort_done_reg[acc_idx];
            rdata_reg[cmdc_pkg::ST_RTR_BIT] <= rtr_reg[acc_idx];
            rdata_reg[cmdc_pkg::ST_DLC_LSB +: cmdc_pkg::DLC_W] <= dlc_reg[acc_idx];
          end
          // Locked words read as zero so software never sees a half-updated frame
          cmdc_pkg::DATA_LOW_OFF: begin
            if (ready_reg[acc_idx]) begin
              rdata_reg <= data_low_reg[acc_idx];
            end
          end
          cmdc_pkg::DATA_HIGH_OFF: begin
            if (ready_reg[acc_idx]) begin
              rdata_reg <= data_high_reg[acc_idx];
            end
          end
          default: begin
            rdata_reg <= cmdc_pkg::ZERO_WORD;
          end
        endcase
      end
    end
  end

  assign avs_readdata = rdata_reg;

  // Mailbox mode: object type and transmit priority
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < N_MB; i++) begin
        obj_reg[i] <= cmdc_pkg::OBJ_DISABLED;
        prio_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N_MB; i++) begin
        if (mode_wr[i]) begin
          obj_reg[i] <= avs_writedata[cmdc_pkg::MODE_TYPE_LSB +: cmdc_pkg::TYPE_W];
          prio_reg[i] <= avs_writedata[cmdc_pkg::MODE_PRIO_LSB +: PW];
        end
      end
    end
  end

  // Data words: received frames take precedence over a software write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < N_MB; i++) begin
        data_low_reg[i] <= cmdc_pkg::ZERO_WORD;
        data_high_reg[i] <= cmdc_pkg::ZERO_WORD;
      end
    end else begin
      for (int i = 0; i < N_MB; i++) begin
        if (rx_store[i]) begin
          data_low_reg[i] <= rx_frame.data_low;
          data_high_reg[i] <= rx_frame.data_high;
        end else begin
          if (dl_wr[i]) begin
            data_low_reg[i] <= avs_writedata;
          end
          if (dh_wr[i]) begin
            data_high_reg[i] <= avs_writedata;
          end
        end
      end
    end
  end

  // Length code and RTR: written length for transmit and producer, written RTR for transmit only, received values for receivers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < N_MB; i++) begin
        dlc_reg[i] <= '0;
      end
      rtr_reg <= '0;
    end else begin
      for (int i = 0; i < N_MB; i++) begin
        if (rx_store[i]) begin
          dlc_reg[i] <= rx_frame.dlc;
          rtr_reg[i] <= rx_frame.rtr;
        end else if (cmd_wr[i]) begin
          if (is_type(obj_reg[i], cmdc_pkg::OBJ_TX) || is_type(obj_reg[i], cmdc_pkg::OBJ_PRODUCER)) begin
            dlc_reg[i] <= avs_writedata[cmdc_pkg::CMD_DLC_LSB +: cmdc_pkg::DLC_W];
          end
          if (is_type(obj_reg[i], cmdc_pkg::OBJ_TX)) begin
            rtr_reg[i] <= avs_writedata[cmdc_pkg::CMD_RTR_BIT];
          end
        end
      end
    end
  end

  // Status and transfer flags; later assignments override, so hardware sets win over clears
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ready_reg <= '0;
      abort_done_reg <= '0;
      ignored_reg <= '0;
      pending_reg <= '0;
      remote_seen_reg <= '0;
      remote_sent_reg <= '0;
    end else begin
      for (int i = 0; i < N_MB; i++) begin
        if (status_rd[i]) begin
          ignored_reg[i] <= 1'b0;
        end
        // A new object type restarts the mailbox; transmit and producer objects start out ready
        if (mode_wr[i]) begin
          ready_reg[i] <= is_type(avs_writedata[cmdc_pkg::MODE_TYPE_LSB +: cmdc_pkg::TYPE_W], cmdc_pkg::OBJ_TX)
                          || is_type(avs_writedata[cmdc_pkg::MODE_TYPE_LSB +: cmdc_pkg::TYPE_W],
                                     cmdc_pkg::OBJ_PRODUCER);
          abort_done_reg[i] <= 1'b0;
          ignored_reg[i] <= 1'b0;
          pending_reg[i] <= 1'b0;
          remote_seen_reg[i] <= 1'b0;
          remote_sent_reg[i] <= 1'b0;
        end
        if (xfer_cmd[i] && !is_type(obj_reg[i], cmdc_pkg::OBJ_DISABLED)) begin
          ready_reg[i] <= 1'b0;
          abort_done_reg[i] <= 1'b0;
          pending_reg[i] <= 1'b1;
          remote_seen_reg[i] <= 1'b0;
          remote_sent_reg[i] <= 1'b0;
        end
        // Abort only reaches senders whose frame has not gone to the transceiver
        if (abort_cmd[i] && (pending_reg[i] || xfer_cmd[i]) && !in_flight[i]
            && (is_type(obj_reg[i], cmdc_pkg::OBJ_TX)
                || (is_type(obj_reg[i], cmdc_pkg::OBJ_CONSUMER) && !remote_sent_reg[i])
                || is_type(obj_reg[i], cmdc_pkg::OBJ_PRODUCER))) begin
          pending_reg[i] <= 1'b0;
          remote_seen_reg[i] <= 1'b0;
          abort_done_reg[i] <= 1'b1;
        end
        // Completion of a transmission handed to the engine
        if (done_hit[i]) begin
          if (is_type(obj_reg[i], cmdc_pkg::OBJ_CONSUMER)) begin
            remote_sent_reg[i] <= 1'b1;
          end else begin
            ready_reg[i] <= 1'b1;
            pending_reg[i] <= 1'b0;
            remote_seen_reg[i] <= 1'b0;
          end
        end
        // Incoming frames
        if (rx_hit[i]) begin
          if (rx_store[i]) begin
            ready_reg[i] <= 1'b1;
            if (ready_reg[i]) begin
              ignored_reg[i] <= 1'b1;
            end
          end else if ((is_type(obj_reg[i], cmdc_pkg::OBJ_RX) || is_type(obj_reg[i], cmdc_pkg::OBJ_CONSUMER))
                       && pending_reg[i]) begin
            ignored_reg[i] <= 1'b1;
          end else if (is_type(obj_reg[i], cmdc_pkg::OBJ_PRODUCER) && rx_frame.rtr) begin
            if (pending_reg[i]) begin
              remote_seen_reg[i] <= 1'b1;
            end else begin
              ignored_reg[i] <= 1'b1;
            end
          end
        end
      end
    end
  end

  // Offer the arbitration winner; the frame is rebuilt every idle cycle so a late
  // higher-priority request can still overtake before the engine accepts
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      offer_reg <= 1'b0;
      offer_frame_reg <= '0;
    end else if (tx_state_reg == cmdc_pkg::TX_IDLE && !(tx_valid && tx_ready)) begin
      offer_reg <= |cand;
      offer_frame_reg.mb <= winner;
      offer_frame_reg.data_low <= data_low_reg[winner];
      offer_frame_reg.data_high <= data_high_reg[winner];
      offer_frame_reg.dlc <= dlc_reg[winner];
      offer_frame_reg.rtr <= is_type(obj_reg[winner], cmdc_pkg::OBJ_CONSUMER)
                             || (is_type(obj_reg[winner], cmdc_pkg::OBJ_TX) && rtr_reg[winner]);
    end else begin
      offer_reg <= 1'b0;
    end
  end

  // Withdraw at once when the offered mailbox is aborted or leaves the candidate set
  assign tx_valid = offer_reg && (tx_state_reg == cmdc_pkg::TX_IDLE) && cand[offer_frame_reg.mb];
  assign tx_frame = offer_frame_reg;

  // Transmit engine: busy from acceptance until done or lost arbitration
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_state_reg <= cmdc_pkg::TX_IDLE;
      busy_mb_reg <= '0;
    end else begin
      unique case (tx_state_reg)
        cmdc_pkg::TX_IDLE: begin
          if (tx_valid && tx_ready) begin
            tx_state_reg <= cmdc_pkg::TX_BUSY;
            busy_mb_reg <= offer_frame_reg.mb;
          end
        end
        cmdc_pkg::TX_BUSY: begin
          if (tx_done || tx_lost) begin
            tx_state_reg <= cmdc_pkg::TX_IDLE;
          end
        end
      endcase
    end
  end

  // Abort completion request line
  assign abort_irq = |abort_done_reg;

endmodule : cmdc_mailbox

// *** verification/cmdc_mailbox_assertions.sv ***
// Port checker for the mailbox data and command block
`timescale 1ns/10ps
module cmdc_mailbox_assertions #(
  parameter int N_MB = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire cmdc_pkg::cmdc_frame_type tx_frame,
  input wire logic tx_done,
  input wire logic tx_lost,
  input wire logic rx_valid,
  input wire cmdc_pkg::cmdc_frame_type rx_frame,
  input wire logic abort_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic busy_reg;
  wire ack = avs_write && !avs_waitrequest;
  wire all_ones = &avs_writedata[N_MB-1:0];
  // Engine owns a frame from accept until done or lost
  always_ff @(posedge clk_sys) begin
    if (reset || tx_done || tx_lost) begin
      busy_reg <= 1'b0;
    end else if (tx_valid && tx_ready) begin
      busy_reg <= 1'b1;
    end
  end
  property p_wait; $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("waitrequest not one cycle");
  property p_rd_hold; !avs_read |=> $stable(avs_readdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("readdata moved without read");
  property p_cmd_zero; avs_read && !avs_waitrequest && avs_address[11:9] == cmdc_pkg::MB_REGION_ID
    && avs_address[4:0] == cmdc_pkg::COMMAND_OFF |-> avs_readdata == cmdc_pkg::ZERO_WORD; endproperty
  a_cmd_zero: assert property (p_cmd_zero) else $error("command register readable");
  property p_no_offer; busy_reg |-> !tx_valid; endproperty
  a_no_offer: assert property (p_no_offer) else $error("offer while engine busy");
  property p_reoffer; tx_lost |-> ##[1:4] tx_valid; endproperty
  a_reoffer: assert property (p_reoffer) else $error("lost frame not offered again");
  property p_irq_cause; $rose(abort_irq) |-> $past(ack && (avs_address == cmdc_pkg::GLOBAL_ABORT_OFF
    || avs_address[4:0] == cmdc_pkg::COMMAND_OFF)); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without abort write");
  property p_irq_clr; ack && avs_address == cmdc_pkg::GLOBAL_TRANSFER_OFF && all_ones |=> !abort_irq;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("transfer left abort flag");
  property p_gabort; ack && avs_address == cmdc_pkg::GLOBAL_ABORT_OFF && all_ones && !busy_reg
    && !tx_ready |-> ##2 !tx_valid; endproperty
  a_gabort: assert property (p_gabort) else $error("offer survived global abort");
  c_accept: cover property (tx_valid && tx_ready);
  c_irq: cover property ($rose(abort_irq));
  c_lost: cover property (tx_lost);
endmodule : cmdc_mailbox_assertions
bind cmdc_mailbox cmdc_mailbox_assertions #(.N_MB(N_MB)) u_chk (.*);

// *** verification/cmdc_engine_model.sv ***
// Behavioural protocol engine standing for the CAN bus side
`timescale 1ns/10ps
module cmdc_engine_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic stall,
  input wire logic lose,
  input wire logic tx_valid,
  input wire cmdc_pkg::cmdc_frame_type tx_frame,
  output logic tx_ready,
  output logic tx_done,
  output logic tx_lost
);
  cmdc_pkg::cmdc_frame_type q[$];
  cmdc_pkg::cmdc_frame_type held_reg;
  int cnt_reg;
  // Accepts only when idle; stall models a busy bus
  assign tx_ready = !stall && cnt_reg == 0;
  // Frame leaves three cycles after accept, or is lost while lose is set
  always_ff @(posedge clk_sys) begin
    tx_done <= 1'b0;
    tx_lost <= 1'b0;
    if (reset) begin
      cnt_reg <= 0;
    end else if (tx_valid && tx_ready) begin
      held_reg <= tx_frame;
      cnt_reg <= 3;
    end else if (cnt_reg > 0) begin
      cnt_reg <= cnt_reg - 1;
      if (cnt_reg == 1 && lose) begin
        tx_lost <= 1'b1;
      end else if (cnt_reg == 1) begin
        tx_done <= 1'b1;
        q.push_back(held_reg);
      end
    end
  end
endmodule : cmdc_engine_model

// *** verification/cmdc_mailbox_tb.sv ***
// Self-checking bench for the mailbox data and command block
`timescale 1ns/10ps
module cmdc_mailbox_tb;
  logic clk_sys, reset, avs_read, avs_write, rx_valid, stall, lose;
  logic avs_waitrequest, tx_valid, tx_ready, tx_done, tx_lost, abort_irq;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, d;
  cmdc_pkg::cmdc_frame_type tx_frame, rx_frame, f;
  cmdc_pkg::cmdc_frame_type all_m = '1;
  cmdc_pkg::cmdc_frame_type mb_m = '{4'hf, '0, '0, 4'h0, 1'b0};
  cmdc_pkg::cmdc_frame_type nodlc_m = '{4'hf, '1, '1, 4'h0, 1'b1};
  logic [2:0] tp[6] = '{3, 3, 3, 4, 5, 1};
  logic [3:0] pr[6] = '{2, 1, 1, 3, 0, 0};
  int n_mismatch = 0;
  int tests_run = 0;
  cmdc_mailbox DUT (.*);
  cmdc_engine_model M (.*);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  function automatic logic [11:0] ma(input int i, input logic [4:0] o);
    return {cmdc_pkg::MB_REGION_ID, 4'(i), o};
  endfunction : ma
  function automatic cmdc_pkg::cmdc_frame_type tf(input int i, input logic [3:0] c, input logic r);
    return '{4'(i), 32'h2000_0000 + 32'(i), 32'h1000_0000 + 32'(i), c, r};
  endfunction : tf
  // Holds the request until waitrequest is seen low, then releases it
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    // Waitrequest is looked at on rising edges only; the write lands and read data is taken at that edge
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k == 50) n_mismatch++;
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : acc
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    acc(1'b1, a, v);
  endtask : wr
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0000_0000);
    chk($sformatf("read %h", a), e, d);
  endtask : rc
  // Waits a bounded time for the next frame sent on the bus
  task automatic chkf(input cmdc_pkg::cmdc_frame_type e, input cmdc_pkg::cmdc_frame_type m);
    repeat (60) if (M.q.size() == 0) @(posedge clk_sys);
    f = (M.q.size() != 0) ? M.q.pop_front() : 'x;
    tests_run++;
    if ((f & m) !== (e & m)) begin
      n_mismatch++;
      $display("wrong value frame expected %h seen %h", e, f);
    end
  endtask : chkf
  // Idle frame lines carry inverted bits so stale data never looks valid
  task automatic rx(input cmdc_pkg::cmdc_frame_type e);
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx_frame <= e;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_frame <= ~e;
  endtask : rx
  task automatic end_sim();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (6000) @(posedge clk_sys);
    n_mismatch++;
    end_sim();
  end
  initial begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 12'h000;
    avs_writedata = 32'h0000_0000;
    rx_valid = 1'b0;
    rx_frame = '0;
    stall = 1'b0;
    lose = 1'b0;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    // Data words are open only where the mode leaves the ready flag set
    for (int i = 0; i < 6; i++) begin
      wr(ma(i, cmdc_pkg::MODE_OFF), {5'h00, tp[i], 4'h0, pr[i], 16'h0000});
      wr(ma(i, cmdc_pkg::DATA_LOW_OFF), tf(i, 0, 0).data_low);
      wr(ma(i, cmdc_pkg::DATA_HIGH_OFF), tf(i, 0, 0).data_high);
      rc(ma(i, cmdc_pkg::DATA_LOW_OFF), (tp[i] == 3 || tp[i] == 5) ? tf(i, 0, 0).data_low : 0);
      rc(ma(i, cmdc_pkg::DATA_HIGH_OFF), (tp[i] == 3 || tp[i] == 5) ? tf(i, 0, 0).data_high : 0);
    end
    wr(ma(0, cmdc_pkg::COMMAND_OFF), 32'hff20_ffff);
    rc(ma(0, cmdc_pkg::COMMAND_OFF), 32'h0000_0000);
    rc(ma(0, cmdc_pkg::STATUS_OFF), 32'h0080_0000 & 32'h0080_0000);
    chk("ready", 1, d[cmdc_pkg::ST_READY_BIT]);
    rc(12'h008, 32'h0000_0000);
    // Three transmit requests queue up behind a stalled bus
    stall <= 1'b1;
    wr(ma(0, cmdc_pkg::COMMAND_OFF), 32'h0084_0000);
    wr(ma(1, cmdc_pkg::COMMAND_OFF), 32'h0098_0000);
    wr(ma(2, cmdc_pkg::COMMAND_OFF), 32'h0082_0000);
    wr(ma(1, cmdc_pkg::DATA_LOW_OFF), 32'hdead_0000);
    rc(ma(1, cmdc_pkg::DATA_LOW_OFF), 32'h0000_0000);
    rc(ma(1, cmdc_pkg::STATUS_OFF), 32'h0018_0000);
    chk("ready", 0, d[cmdc_pkg::ST_READY_BIT]);
    lose <= 1'b1;
    stall <= 1'b0;
    repeat (40) if (!tx_lost) @(posedge clk_sys);
    lose <= 1'b0;
    chkf(tf(1, 8, 1), all_m);
    chkf(tf(2, 2, 0), all_m);
    chkf(tf(0, 4, 0), all_m);
    rc(ma(1, cmdc_pkg::DATA_LOW_OFF), tf(1, 0, 0).data_low);
    // Aborts on a stalled bus raise the interrupt
    stall <= 1'b1;
    wr(ma(0, cmdc_pkg::COMMAND_OFF), 32'h0080_0000);
    wr(ma(0, cmdc_pkg::COMMAND_OFF), 32'h0040_0000);
    // The flag settles on the edge that ends the write, so look half a cycle later
    @(negedge clk_sys);
    chk("irq", 1, abort_irq);
    wr(cmdc_pkg::GLOBAL_TRANSFER_OFF, 32'h0000_000a);
    wr(cmdc_pkg::GLOBAL_ABORT_OFF, 32'h0000_ffff);
    rc(ma(3, cmdc_pkg::STATUS_OFF), 32'h0040_0000);
    chk("abort", 1, d[cmdc_pkg::ST_ABORT_BIT]);
    wr(cmdc_pkg::GLOBAL_TRANSFER_OFF, 32'h0000_ffff);
    @(negedge clk_sys);
    chk("irq", 0, abort_irq);
    stall <= 1'b0;
    chkf(tf(1, 0, 0), mb_m);
    chkf(tf(2, 0, 0), mb_m);
    chkf(tf(0, 0, 0), mb_m);
    chkf('{4'd3, '0, '0, 4'h0, 1'b1}, '{4'hf, '0, '0, 4'h0, 1'b1});
    // Producer answers a remote frame only while armed
    rx('{4'd4, '0, '0, 4'h0, 1'b1});
    chkf(tf(4, 0, 0), nodlc_m);
    wr(ma(4, cmdc_pkg::COMMAND_OFF), 32'h0086_0000);
    wr(ma(4, cmdc_pkg::COMMAND_OFF), 32'h0040_0000);
    rx('{4'd4, '0, '0, 4'h0, 1'b1});
    repeat (20) @(posedge clk_sys);
    chk("frames", 0, M.q.size());
    // Receive mailbox takes the frame and opens its data words
    rx('{4'd5, 32'haaaa_0001, 32'h5555_0001, 4'h8, 1'b0});
    rc(ma(5, cmdc_pkg::DATA_LOW_OFF), 32'h5555_0001);
    rc(ma(5, cmdc_pkg::DATA_HIGH_OFF), 32'haaaa_0001);
    // Overwrite mailbox keeps the newest frame; the first status read shows the ignored flag and clears it
    wr(ma(6, cmdc_pkg::MODE_OFF), 32'h0200_0000);
    wr(ma(6, cmdc_pkg::COMMAND_OFF), 32'h0080_0000);
    rx('{4'd6, 32'h3333_0001, 32'h4444_0001, 4'h2, 1'b0});
    rx('{4'd6, 32'hbbbb_0002, 32'hcccc_0002, 4'h4, 1'b0});
    rc(ma(6, cmdc_pkg::STATUS_OFF), 32'h0184_0000);
    rc(ma(6, cmdc_pkg::DATA_LOW_OFF), 32'hcccc_0002);
    rc(ma(6, cmdc_pkg::DATA_HIGH_OFF), 32'hbbbb_0002);
    rc(ma(6, cmdc_pkg::STATUS_OFF), 32'h0084_0000);
    end_sim();
  end
endmodule : cmdc_mailbox_tb
